// ### thbm_pkg.sv
// constants for the two-hand button monitor: register map, diagnostic
// codes, field positions and timing; shared by the top and its leaves
package thbm_pkg;

  // scan clock and synchronism window
  localparam int CLK_KHZ   = 25000;          // 25 MHz system clock
  localparam int WINDOW_MS = 500;            // both hands within this time
  localparam int WINDOW_CYC = WINDOW_MS * CLK_KHZ; // ms * kHz = cycles
  localparam int TMR_W     = 24;

  // instance capacity of the relay
  localparam logic [31:0] CAP_SINGLE = 32'h0000_0007;
  localparam logic [31:0] CAP_DUAL   = 32'h0000_0003;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIAG   = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MK = 8'h10;
  localparam logic [7:0] OFS_CAP    = 8'h14;

  // control fields
  localparam int CTRL_SINGLE = 0;   // 1: single_channel_eval
  localparam int CTRL_EXTGT  = 1;   // 1: ext_gate_required
  localparam logic [1:0] CTRL_RST = 2'h0; // dual channel, no external gate

  // status fields
  localparam int ST_RELEASE = 0;
  localparam int ST_FAULT   = 1;
  localparam int ST_ACTIVE  = 2;

  // interrupt event bits
  localparam int EV_W        = 3;
  localparam int EV_REL_ON   = 0;
  localparam int EV_FAULT    = 1;
  localparam int EV_REL_OFF  = 2;

  // diagnostic codes
  localparam logic [31:0] DG_NO_ENABLE = 32'h0000_0000;
  localparam logic [31:0] DG_WAIT_1ST  = 32'h0000_2001;
  localparam logic [31:0] DG_ONE_OPEN  = 32'h0000_2005;
  localparam logic [31:0] DG_NORMAL    = 32'h0000_2016;
  localparam logic [31:0] DG_UNDEF_B1  = 32'h0000_2017;
  localparam logic [31:0] DG_UNDEF_B2  = 32'h0000_2018;
  localparam logic [31:0] DG_OPERATED  = 32'h0000_800B;
  localparam logic [31:0] DG_TOO_LATE  = 32'h0000_F006;
  localparam logic [31:0] DG_ONE_CHAN  = 32'h0000_F00E;
  localparam logic [31:0] DG_STARTUP   = 32'h0000_F018;

  // monitor states
  typedef enum logic [2:0] {
    THBM_IDLE, THBM_START, THBM_WAIT1, THBM_WAIT2,
    THBM_REL, THBM_REST, THBM_ERR
  } thbm_state_t;

endpackage

// ### thbm_sync.sv
// two-flop synchroniser for the contact inputs and activation coil
// assumes asynchronous pins; nothing may read the first stage
`timescale 1ns/100ps
module thbm_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // plain shift; reset to all zeros, which is not the rest level of the break inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// ### thbm_timer.sv
// synchronism window timer: counts scan clock ticks while run is high
// assumes run drops for at least one cycle between two windows
`timescale 1ns/100ps
module thbm_timer #(
  parameter int LIMIT = thbm_pkg::WINDOW_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control and result
  input  wire logic run,
  output logic      expired
);

  localparam logic [thbm_pkg::TMR_W-1:0] LIM =
    thbm_pkg::TMR_W'(LIMIT);

  logic [thbm_pkg::TMR_W-1:0] cnt_r;
  logic [thbm_pkg::TMR_W-1:0] cnt_nxt;

  // saturate at the limit so a long wait never wraps back to valid
  always_comb begin
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r < LIM) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = (cnt_r >= LIM);

endmodule

// ### thbm_top.sv
// two-hand button monitor: contact evaluation, release and fault
// contacts, diagnostic word and an APB register slave with interrupt
// assumes contacts arrive asynchronously on pins; APB on SYS_CLK
//
// Notes on behaviour
// R01 - single channel: two makes on button1 inputs
// R02 - dual channel make/break pairs; default setting
// R03 - wiring order of makes and breaks
// R04 - button2 inputs used only in dual
// R05 - optional external gate; default runs ungated
// R06 - release closes only on correct actuation
// R07 - fault contact closed while error present
// R08 - diagnostic word shows state or error
// R09 - codes 0000, 2001 and 2005
// R10 - codes 2016, 2017 and 2018
// R11 - code 800B while released
// R12 - F006 when second hand too late
// R13 - F00E when one channel opened, closed
// R14 - F018 when input actuated at startup
// R15 - capacity seven single or three dual
// R16 - both hands within 500 ms
// R17 - leaving actuation drops release at once
// R18 - timing error clears only at rest
// R19 - sample per scan; count window ticks
`timescale 1ns/100ps
module thbm_top #(
  parameter int WINDOW_CYC = thbm_pkg::WINDOW_CYC
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // contact inputs from the pushbutton station and the activation coil
  input  wire logic        BUTTON1_MAKE_INPUT,
  input  wire logic        BUTTON1_BREAK_INPUT,
  input  wire logic        BUTTON2_MAKE_INPUT,
  input  wire logic        BUTTON2_BREAK_INPUT,
  input  wire logic        BLOCK_ACTIVATION_COIL,
  // monitor outputs
  output logic             RELEASE_CONTACT,
  output logic             FAULT_CONTACT,
  output logic [31:0]      DIAG_WORD,
  output logic             IRQ,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  // every check below runs on the scan clock and sleeps in reset
  default clocking chk_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // synchronised inputs: make1, break1, make2, break2, coil
  logic [4:0] pin_s;
  logic       mk1, bk1, mk2, bk2, coil_s;

  // sample every pin once per scan clock [R19]
  thbm_sync #(.W(5)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     ({BLOCK_ACTIVATION_COIL, BUTTON2_BREAK_INPUT,
             BUTTON2_MAKE_INPUT, BUTTON1_BREAK_INPUT,
             BUTTON1_MAKE_INPUT}),
    .q     (pin_s)
  );

  assign mk1    = pin_s[0];
  assign bk1    = pin_s[1];
  assign mk2    = pin_s[2];
  assign bk2    = pin_s[3];
  assign coil_s = pin_s[4];

  // control register bits
  logic [1:0] ctrl_r, ctrl_nxt;
  logic       single, ext_gate;
  assign single   = ctrl_r[thbm_pkg::CTRL_SINGLE];
  assign ext_gate = ctrl_r[thbm_pkg::CTRL_EXTGT];

  // hand position from a make and a break contact; {actuated, rest}
  function automatic logic [1:0] hand_pos(input logic mk,
                                          input logic bk,
                                          input logic one_ch);
    if (one_ch) begin
      hand_pos = {mk, !mk};
    end else begin
      hand_pos = {mk && !bk, !mk && bk};
    end
  endfunction

  logic [1:0] h1, h2;
  logic       both_act, all_rest, active;

  // in single mode the second hand is the button1 break input [R01]
  // and the button2 pair is only looked at in dual mode [R04] [R03]
  always_comb begin
    h1 = hand_pos(mk1, bk1, single);
    if (single) begin
      h2 = hand_pos(bk1, 1'b0, 1'b1);
    end else begin
      h2 = hand_pos(mk2, bk2, 1'b0);                    // [R02]
    end
  end

  assign both_act = h1[1] && h2[1];
  assign all_rest = h1[0] && h2[0];
  assign active   = !ext_gate || coil_s;                  // [R05]

  // window timer runs from the first input change on
  logic tmr_done, settled_r, settled_nxt;
  thbm_pkg::thbm_state_t state_r, state_nxt;
  logic [31:0] err_r, err_nxt;

  thbm_timer #(.LIMIT(WINDOW_CYC)) u_tmr (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .run     (state_r == thbm_pkg::THBM_WAIT2),         // [R19]
    .expired (tmr_done)
  );

  // monitor sequencing
  always_comb begin
    state_nxt = state_r;
    err_nxt   = err_r;
    settled_nxt = 1'b1;   // start check waits for real pin levels
    if (!active) begin
      state_nxt = thbm_pkg::THBM_IDLE;                    // [R05]
    end else begin
      case (state_r)
        thbm_pkg::THBM_IDLE: begin
          state_nxt = settled_r ? thbm_pkg::THBM_START : thbm_pkg::THBM_IDLE;
        end
        thbm_pkg::THBM_START: begin
          if (!all_rest) begin
            state_nxt = thbm_pkg::THBM_ERR;               // [R14]
            err_nxt   = thbm_pkg::DG_STARTUP;
          end else begin
            state_nxt = thbm_pkg::THBM_WAIT1;
          end
        end
        thbm_pkg::THBM_WAIT1: begin
          if (!all_rest) begin
            state_nxt = thbm_pkg::THBM_WAIT2;
          end
        end
        thbm_pkg::THBM_WAIT2: begin
          if (both_act && !tmr_done) begin
            state_nxt = thbm_pkg::THBM_REL;               // [R16]
          end else if (tmr_done) begin
            state_nxt = thbm_pkg::THBM_ERR;               // [R12]
            err_nxt   = thbm_pkg::DG_TOO_LATE;
          end else if (all_rest) begin
            state_nxt = thbm_pkg::THBM_ERR;               // [R13]
            err_nxt   = thbm_pkg::DG_ONE_CHAN;
          end
        end
        thbm_pkg::THBM_REL: begin
          if (!both_act) begin
            state_nxt = thbm_pkg::THBM_REST;              // [R17]
          end
        end
        thbm_pkg::THBM_REST: begin
          if (all_rest) begin
            state_nxt = thbm_pkg::THBM_WAIT1;
          end
        end
        thbm_pkg::THBM_ERR: begin
          if (all_rest) begin
            state_nxt = thbm_pkg::THBM_WAIT1;             // [R18]
          end
        end
        default: begin
          state_nxt = thbm_pkg::THBM_IDLE;
        end
      endcase
    end
  end

  // diagnostic code for the current state
  logic [31:0] diag_nxt;
  always_comb begin
    case (state_r)
      thbm_pkg::THBM_IDLE:  diag_nxt = thbm_pkg::DG_NO_ENABLE;  // [R09]
      thbm_pkg::THBM_WAIT1: begin
        if (all_rest) begin
          diag_nxt = thbm_pkg::DG_NORMAL;                 // [R10]
        end else if (!h1[0] && !h1[1]) begin
          diag_nxt = thbm_pkg::DG_UNDEF_B1;
        end else if (!h2[0] && !h2[1]) begin
          diag_nxt = thbm_pkg::DG_UNDEF_B2;
        end else begin
          diag_nxt = thbm_pkg::DG_WAIT_1ST;
        end
      end
      thbm_pkg::THBM_WAIT2: diag_nxt = thbm_pkg::DG_ONE_OPEN;   // [R09]
      thbm_pkg::THBM_REL:   diag_nxt = thbm_pkg::DG_OPERATED;   // [R11]
      thbm_pkg::THBM_ERR:   diag_nxt = err_r;                   // [R08]
      default:              diag_nxt = thbm_pkg::DG_WAIT_1ST;
    endcase
  end

  // release follows the next state so it drops the cycle after a change
  logic rel_r, flt_r;
  logic [31:0] diag_r;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= thbm_pkg::THBM_IDLE;
      settled_r <= 1'b0;  // sync reset zeros look like undefined hands
      err_r   <= thbm_pkg::DG_NO_ENABLE;
      rel_r   <= 1'b0;
      flt_r   <= 1'b0;
      diag_r  <= thbm_pkg::DG_NO_ENABLE;
    end else begin
      state_r <= state_nxt;
      settled_r <= settled_nxt;
      err_r   <= err_nxt;
      rel_r   <= (state_nxt == thbm_pkg::THBM_REL);     // [R06]
      flt_r   <= (state_nxt == thbm_pkg::THBM_ERR);     // [R07]
      diag_r  <= diag_nxt;
    end
  end

  assign RELEASE_CONTACT = rel_r;
  assign FAULT_CONTACT   = flt_r;
  assign DIAG_WORD       = diag_r;

  // interrupt events from contact edges; set wins over clear
  logic [thbm_pkg::EV_W-1:0] ev, ist_r, ist_nxt, imk_r, imk_nxt;
  logic rel_d_r, flt_d_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic        err_pend_r, err_pend_nxt;
  logic        setup, wr_acc;

  assign ev[thbm_pkg::EV_REL_ON]  = rel_r && !rel_d_r;
  assign ev[thbm_pkg::EV_FAULT]   = flt_r && !flt_d_r;
  assign ev[thbm_pkg::EV_REL_OFF] = !rel_r && rel_d_r;

  assign setup  = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;

  // register writes in the access phase; read data capture in the setup phase
  always_comb begin
    ctrl_nxt     = ctrl_r;
    imk_nxt      = imk_r;
    ist_nxt      = ist_r;
    rdata_nxt    = rdata_r;
    err_pend_nxt = err_pend_r;
    if (wr_acc) begin
      if (PADDR == thbm_pkg::OFS_CTRL) begin
        ctrl_nxt = PWDATA[1:0];
      end else if (PADDR == thbm_pkg::OFS_IRQ_ST) begin
        ist_nxt = ist_r & ~PWDATA[thbm_pkg::EV_W-1:0];
      end else if (PADDR == thbm_pkg::OFS_IRQ_MK) begin
        imk_nxt = PWDATA[thbm_pkg::EV_W-1:0];
      end
    end
    ist_nxt = ist_nxt | ev;
    if (setup) begin
      rdata_nxt    = '0;
      err_pend_nxt = 1'b0;
      if (PADDR == thbm_pkg::OFS_CTRL) begin
        rdata_nxt[1:0] = ctrl_r;
      end else if (PADDR == thbm_pkg::OFS_STATUS) begin
        rdata_nxt[thbm_pkg::ST_RELEASE] = rel_r;
        rdata_nxt[thbm_pkg::ST_FAULT]   = flt_r;
        rdata_nxt[thbm_pkg::ST_ACTIVE]  = active;
      end else if (PADDR == thbm_pkg::OFS_DIAG) begin
        rdata_nxt = diag_r;
      end else if (PADDR == thbm_pkg::OFS_IRQ_ST) begin
        rdata_nxt[thbm_pkg::EV_W-1:0] = ist_r;
      end else if (PADDR == thbm_pkg::OFS_IRQ_MK) begin
        rdata_nxt[thbm_pkg::EV_W-1:0] = imk_r;
      end else if (PADDR == thbm_pkg::OFS_CAP) begin
        // capacity depends on the evaluation mode [R15]
        rdata_nxt = single ? thbm_pkg::CAP_SINGLE : thbm_pkg::CAP_DUAL;
      end else begin
        err_pend_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r     <= thbm_pkg::CTRL_RST;                   // [R02]
      imk_r      <= '0;
      ist_r      <= '0;
      rdata_r    <= '0;
      err_pend_r <= 1'b0;
      rel_d_r    <= 1'b0;
      flt_d_r    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      imk_r      <= imk_nxt;
      ist_r      <= ist_nxt;
      rdata_r    <= rdata_nxt;
      err_pend_r <= err_pend_nxt;
      rel_d_r    <= rel_r;
      flt_d_r    <= flt_r;
    end
  end

  // zero wait states: every access phase completes at once
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && err_pend_r;
  assign PRDATA  = rdata_r;
  assign IRQ     = |(ist_r & imk_r);

  // checks on the monitor
  gate_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R05]
    (ext_gate && !coil_s) |=> !rel_r)
    else $error("release closed while gate is off");

  release_cause_a: assert property ( // [R06]
    $rose(rel_r) |-> $past(both_act) && !$past(tmr_done) && $past(active))
    else $error("release closed without valid actuation");

  fault_code_a: assert property ( // [R07]
    flt_r |-> (err_r == thbm_pkg::DG_TOO_LATE ||
               err_r == thbm_pkg::DG_ONE_CHAN ||
               err_r == thbm_pkg::DG_STARTUP))
    else $error("fault contact without error code");

  idle_diag_a: assert property ( // [R09]
    !active |-> ##2 (diag_r == thbm_pkg::DG_NO_ENABLE))
    else $error("diag not zero while inactive");

  operated_diag_a: assert property ( // [R11]
    rel_r |=> (diag_r == thbm_pkg::DG_OPERATED))
    else $error("diag not 800B while released");

  late_diag_a: assert property ( // [R12]
    (active && state_r == thbm_pkg::THBM_WAIT2 && tmr_done)
      |-> ##2 (diag_r == thbm_pkg::DG_TOO_LATE) && flt_d_r)
    else $error("late second hand not flagged");

  one_chan_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R13]
    (active && state_r == thbm_pkg::THBM_WAIT2 && all_rest && !tmr_done)
      |-> ##2 (diag_r == thbm_pkg::DG_ONE_CHAN))
    else $error("one channel cycle not flagged");

  startup_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R14]
    (active && state_r == thbm_pkg::THBM_START && !all_rest)
      |-> ##2 (diag_r == thbm_pkg::DG_STARTUP))
    else $error("startup actuation not flagged");

  drop_out_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
    (rel_r && !both_act) |=> !rel_r)
    else $error("release held after contact change");

  err_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R18]
    (flt_r && active && !all_rest) |=> flt_r)
    else $error("error cleared before rest");

  release_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(rel_r));
  late_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    diag_r == thbm_pkg::DG_TOO_LATE);
  one_chan_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    diag_r == thbm_pkg::DG_ONE_CHAN);
  startup_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    diag_r == thbm_pkg::DG_STARTUP);

endmodule

// ### thbm_station.sv
// operator pushbutton station: turns hand commands into contact levels
// assumes hand codes 0 rest, 1 actuated, 2 undefined (make and break)
`timescale 1ns/100ps
module thbm_station (
  // commands from the bench
  input  wire logic       single_md,
  input  wire logic       stray,
  input  wire logic [1:0] hand1,
  input  wire logic [1:0] hand2,
  // contact levels towards the relay inputs
  output logic            b1_make,
  output logic            b1_break,
  output logic            b2_make,
  output logic            b2_break
);
  // dual wiring: make then break per hand; single: two makes on button1
  always_comb begin
    if (single_md) begin
      b1_make  = (hand1 == 2'h1);
      b1_break = (hand2 == 2'h1);
      // unused pins driven actuated on request to prove they are ignored
      b2_make  = stray;
      b2_break = ~stray;
    end else begin
      b1_make  = (hand1 != 2'h0);
      b1_break = (hand1 != 2'h1);
      b2_make  = (hand2 != 2'h0);
      b2_break = (hand2 != 2'h1);
    end
  end
endmodule

// ### thbm_top_test.sv
// self-checking bench of the two-hand button monitor with APB access
// assumes a short synchronism window parameter to keep the run brief
`timescale 1ns/100ps
module thbm_top_test;
  localparam int WIN = 20;
  `define CHECK(got, exp, msg) begin num_checks++; \
    if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH at %0t: %s", $time, msg); end end

  logic        sys_clk, rst_n, coil, psel, penable, pwrite;
  logic        single_md, stray, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [1:0]  hand1, hand2;
  wire         b1m, b1b, b2m, b2b, rel, flt, irq, pready, pslverr;
  wire  [31:0] diag, prdata;
  int          failures, num_checks, cyc;

  // clock, 40 ns period
  always #20 sys_clk = ~sys_clk;

  thbm_top #(.WINDOW_CYC(WIN)) dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n),
    .BUTTON1_MAKE_INPUT(b1m), .BUTTON1_BREAK_INPUT(b1b),
    .BUTTON2_MAKE_INPUT(b2m), .BUTTON2_BREAK_INPUT(b2b),
    .BLOCK_ACTIVATION_COIL(coil),
    .RELEASE_CONTACT(rel), .FAULT_CONTACT(flt), .DIAG_WORD(diag),
    .IRQ(irq), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));

  thbm_station st_u (
    .single_md(single_md), .stray(stray), .hand1(hand1), .hand2(hand2),
    .b1_make(b1m), .b1_break(b1b), .b2_make(b2m), .b2_break(b2b));

  // hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one APB transfer; data and error taken at the edge pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string msg);
    apb(1'b0, a, 32'h0000_0000);
    `CHECK(rd, e, msg)
  endtask

  // diag is polled, so a one-cycle code is still caught
  task automatic wait_diag(input logic [31:0] code, input int lim,
                           input string msg);
    int n;
    n = 0;
    while (diag !== code && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    `CHECK(diag, code, msg)
  endtask

  task automatic hands(input logic [1:0] a, input logic [1:0] b);
    @(posedge sys_clk);
    hand1 <= a;
    hand2 <= b;
  endtask

  task automatic t_regs();
    rd_chk(thbm_pkg::OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(thbm_pkg::OFS_CAP, thbm_pkg::CAP_DUAL, "cap dual");
    apb(1'b1, thbm_pkg::OFS_CAP, 32'h0000_00FF);
    rd_chk(thbm_pkg::OFS_CAP, thbm_pkg::CAP_DUAL, "cap ro");
    rd_chk(8'h20, 32'h0000_0000, "unmapped data");
    `CHECK(err, 1'b1, "unmapped error")
    wait_diag(thbm_pkg::DG_NORMAL, 10, "rest code");
    $display("test regs done");
  endtask

  task automatic t_release();
    apb(1'b1, thbm_pkg::OFS_IRQ_ST, 32'h0000_0007);
    apb(1'b1, thbm_pkg::OFS_IRQ_MK, 32'h0000_0001);
    hands(2'h1, 2'h0);
    wait_diag(thbm_pkg::DG_WAIT_1ST, 10, "first input");
    wait_diag(thbm_pkg::DG_ONE_OPEN, 10, "one open");
    `CHECK(rel, 1'b0, "early release")
    repeat (4) @(posedge sys_clk);
    hands(2'h1, 2'h1);
    wait_diag(thbm_pkg::DG_OPERATED, 10, "operated");
    `CHECK(rel, 1'b1, "no release")
    `CHECK(flt, 1'b0, "fault on release")
    `CHECK(irq, 1'b1, "irq on release")
    rd_chk(thbm_pkg::OFS_STATUS, 32'h0000_0005, "status");
    apb(1'b1, thbm_pkg::OFS_IRQ_ST, 32'h0000_0001);
    @(posedge sys_clk);
    `CHECK(irq, 1'b0, "irq clear")
    hands(2'h0, 2'h1);
    repeat (4) @(posedge sys_clk);
    `CHECK(rel, 1'b0, "release kept")
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_NORMAL, 10, "back at rest");
    $display("test release done");
  endtask

  task automatic t_late();
    hands(2'h0, 2'h1);
    wait_diag(thbm_pkg::DG_ONE_OPEN, 10, "one open");
    repeat (WIN) @(posedge sys_clk);
    wait_diag(thbm_pkg::DG_TOO_LATE, 20, "too late");
    `CHECK(flt, 1'b1, "fault open")
    hands(2'h1, 2'h1);
    repeat (6) @(posedge sys_clk);
    `CHECK(rel, 1'b0, "late release")
    hands(2'h0, 2'h1);
    repeat (6) @(posedge sys_clk);
    `CHECK(diag, thbm_pkg::DG_TOO_LATE, "cleared early")
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_NORMAL, 10, "error ack");
    `CHECK(flt, 1'b0, "fault stays")
    hands(2'h1, 2'h0);
    wait_diag(thbm_pkg::DG_ONE_OPEN, 10, "one open");
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_ONE_CHAN, 10, "one channel");
    wait_diag(thbm_pkg::DG_NORMAL, 10, "rest again");
    $display("test late done");
  endtask

  task automatic t_single();
    apb(1'b1, thbm_pkg::OFS_CTRL, 32'h0000_0001);
    @(posedge sys_clk);
    single_md <= 1'b1;
    stray     <= 1'b1;
    rd_chk(thbm_pkg::OFS_CAP, thbm_pkg::CAP_SINGLE, "cap one");
    wait_diag(thbm_pkg::DG_NORMAL, 10, "b2 ignored");
    hands(2'h1, 2'h0);
    wait_diag(thbm_pkg::DG_ONE_OPEN, 10, "single one");
    hands(2'h1, 2'h1);
    wait_diag(thbm_pkg::DG_OPERATED, 10, "single both");
    `CHECK(rel, 1'b1, "single release")
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_NORMAL, 10, "single rest");
    @(posedge sys_clk);
    stray <= 1'b0;
    apb(1'b1, thbm_pkg::OFS_CTRL, 32'h0000_0000);
    @(posedge sys_clk);
    single_md <= 1'b0;
    $display("test single done");
  endtask

  task automatic t_gate();
    apb(1'b1, thbm_pkg::OFS_CTRL, 32'h0000_0002);
    wait_diag(thbm_pkg::DG_NO_ENABLE, 10, "gated off");
    hands(2'h1, 2'h0);
    repeat (6) @(posedge sys_clk);
    `CHECK(diag, thbm_pkg::DG_NO_ENABLE, "inactive")
    `CHECK(rel, 1'b0, "inactive release")
    @(posedge sys_clk);
    coil <= 1'b1;
    wait_diag(thbm_pkg::DG_STARTUP, 10, "startup");
    `CHECK(flt, 1'b1, "startup fault")
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_NORMAL, 10, "startup ack");
    @(posedge sys_clk);
    coil <= 1'b0;
    apb(1'b1, thbm_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test gate done");
  endtask

  // an undefined hand shows its code for one cycle, then leaves wait1
  task automatic t_undef();
    hands(2'h2, 2'h0);
    wait_diag(thbm_pkg::DG_UNDEF_B1, 10, "b1 undefined");
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_ONE_CHAN, 10, "b1 undef back");
    wait_diag(thbm_pkg::DG_NORMAL, 10, "b1 rest");
    hands(2'h0, 2'h2);
    wait_diag(thbm_pkg::DG_UNDEF_B2, 10, "b2 undefined");
    hands(2'h0, 2'h0);
    wait_diag(thbm_pkg::DG_ONE_CHAN, 10, "b2 undef back");
    wait_diag(thbm_pkg::DG_NORMAL, 10, "b2 rest");
    $display("test undefined done");
  endtask

  // mid-run reset: defaults return and resting hands raise no error
  task automatic t_reset();
    apb(1'b1, thbm_pkg::OFS_CTRL, 32'h0000_0003);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    `CHECK(diag, thbm_pkg::DG_NO_ENABLE, "diag in reset")
    `CHECK(irq, 1'b0, "irq in reset")
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      `CHECK(flt, 1'b0, "false startup error")
    end
    rd_chk(thbm_pkg::OFS_CTRL, 32'h0000_0000, "ctrl after reset");
    wait_diag(thbm_pkg::DG_NORMAL, 10, "rest after reset");
    $display("test reset done");
  endtask

  initial begin
    sys_clk   = 1'b0;
    rst_n     = 1'b0;
    coil      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    single_md = 1'b0;
    stray     = 1'b0;
    hand1     = 2'h0;
    hand2     = 2'h0;
    failures  = 0;
    num_checks = 0;
    cyc       = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_release();
    t_late();
    t_undef();
    t_single();
    t_gate();
    t_reset();
    give_verdict();
  end
endmodule
